//--- edh_pkg.sv
// Package of constants and types for the error flag and configuration block
package edh_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG   = 8'h00;
  localparam logic [7:0] OFS_SENSE    = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_MASK     = 8'h0c;
  localparam logic [7:0] OFS_COUNTER  = 8'h10;
  localparam logic [7:0] OFS_FLAGS    = 8'h14;
  localparam logic [7:0] OFS_STANDARD = 8'h18;

  // Config field positions
  localparam int CFG_COMPOSITE  = 0;
  localparam int CFG_COMPONENT  = 1;
  localparam int CFG_FIELD_RATE = 2;
  localparam int CFG_OVERRIDE   = 3;
  localparam int CFG_SYNC_ID    = 4;
  localparam int CFG_CLEAR      = 5;
  localparam int CFG_CLR_READ   = 6;
  localparam int CFG_STICKY     = 7;
  localparam int CFG_FLAG_MASK  = 8;

  // Flag layout: ap/ff/anc x {edh,eda,idh,ida,ues}
  localparam int FLG_EDH = 0;
  localparam int FLG_EDA = 1;
  localparam int FLG_IDH = 2;
  localparam int FLG_IDA = 3;
  localparam int FLG_UES = 4;

  // Reset values and counter width
  localparam logic [8:0]  CONFIG_RST = 9'h000;
  localparam logic [14:0] SENSE_RST  = 15'h7fff;
  localparam logic [2:0]  MASK_RST   = 3'h0;
  localparam int          CNT_W      = 21;

  // Interrupt status bit positions
  localparam int IRQ_ERR_FIELD = 0;
  localparam int IRQ_NO_PACKET = 1;
  localparam int IRQ_CNT_WRAP  = 2;

  // Video standard codes
  typedef enum logic [1:0] {
    STD_525_COMPONENT = 2'b00,
    STD_625_COMPONENT = 2'b01,
    STD_525_COMPOSITE = 2'b10,
    STD_625_COMPOSITE = 2'b11
  } edh_std_type;

  // Five flags of one class
  typedef struct packed {
    logic ues;
    logic ida;
    logic idh;
    logic eda;
    logic edh;
  } edh_class_type;

  // Flags of one packet: anc, full field, active picture
  typedef struct packed {
    edh_class_type anc;
    edh_class_type ff;
    edh_class_type ap;
  } edh_flags_type;

  // Per-field report from the stream side
  typedef struct packed {
    logic          field_end;
    logic          packet_seen;
    logic          ap_crc_err;
    logic          ff_crc_err;
    logic          anc_err;
    edh_flags_type in_flags;
    logic          auto_625;
    logic          auto_composite;
  } edh_field_type;

  // AHB-Lite slave request
  typedef struct packed {
    logic        hsel;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic        hready;
  } edh_ahb_req_type;

endpackage : edh_pkg

//--- edh_recode.sv
// Configuration registers, errored field counter and flag recoding
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps

// Operation
// - Override bit picks programmed standard, otherwise standard auto-detected.
// - Field rate bit: 1 gives 625/50, 0 gives 525/60.
// - Component rate bit: 1 gives 18 MHz, 0 gives 13.5 MHz luminance.
// - Composite bit: 1 gives four-times-subcarrier composite, 0 component.
// - Indication select adds sync identifiers to the ancillary indication.
// - Counter clear bit at one resets the errored field counter.
// - Clear-on-read bit clears counter after each counter read.
// - Power-up config zero except sensitivity bits which are one.
// - Standalone keeps defaults; straps 0,1 set indication select.
// - Interrupt drops once the status word (offset 0x08) is read.
// - Local transmission errors raise detected-here for picture or field.
// - Incoming internal-here becomes internal-already; already flags pass.
// - Incoming error-here becomes error-already downstream.
// - Missing packet: new packet generated with unknown status set.
// - Receive mode forwards flags; masking avoids false field errors.
// - Sticky mode holds each flag until read.
// - 21-bit counter increments per field with sensitive error.
module edh_recode
  import edh_pkg::*;
(
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire edh_pkg::edh_ahb_req_type ahb_req,
  input  wire logic [31:0]              hwdata,
  output logic [31:0]                   hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire logic                     address_strap_high,
  input  wire logic                     address_strap_low,
  input  wire edh_pkg::edh_field_type   field_in,
  input  wire logic                     anc_present,
  input  wire logic                     sync_id_present,
  output logic                          anc_indication,
  output edh_pkg::edh_flags_type        flags_out,
  output logic                          packet_generated,
  output logic [1:0]                    video_standard,
  output logic                          irq
);
  import edh_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [1:0]    strap_s1;
    logic [1:0]    strap_s2;
    logic [1:0]    strap_fill;
    logic          strap_done;
    logic [8:0]    config_r;
    logic [14:0]   sense;
    logic [2:0]    irq_stat;
    logic [2:0]    irq_mask;
    logic [CNT_W-1:0] count;
    edh_flags_type held;
    edh_flags_type out_flags;
    logic          generated;
    logic          anc_ind;
    logic [1:0]    std;
    logic          dphase;
    logic          dwrite;
    logic [7:0]    daddr;
    logic [31:0]   rdata;
    logic          irq_o;
  } edh_state_type;

  edh_state_type state_reg;
  edh_state_type state_next;

  localparam edh_state_type STATE_RST = '{
    strap_s1: 2'h0, strap_s2: 2'h0, strap_fill: 2'h0, strap_done: 1'b0,
    config_r: CONFIG_RST, sense: SENSE_RST, irq_stat: 3'h0,
    irq_mask: MASK_RST, count: '0, held: '0, out_flags: '0,
    generated: 1'b0, anc_ind: 1'b0, std: 2'h0, dphase: 1'b0,
    dwrite: 1'b0, daddr: 8'h00, rdata: 32'h0000_0000, irq_o: 1'b0};

  // Recode one class of incoming flags
  function automatic edh_class_type recode(input edh_class_type f,
                                           input logic local_err);
    edh_class_type r;
    r.edh = local_err;
    r.eda = f.edh | f.eda;
    r.idh = 1'b0;
    r.ida = f.idh | f.ida;
    r.ues = f.ues;
    return r;
  endfunction : recode

  // Any set flag of a class that the sensitivity gates
  function automatic logic sensed(input edh_class_type f,
                                  input logic [4:0] s);
    return |(f & s);
  endfunction : sensed

  edh_flags_type rx;
  edh_flags_type fresh;
  logic          ahb_go;
  logic          field_err;
  logic          rd_counter;
  logic          rd_flags;
  logic          rd_status;
  logic          wr_config;
  logic [2:0]    irq_set;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    state_next = state_reg;
    rx         = field_in.packet_seen ? field_in.in_flags : '0;
    ahb_go     = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
    rd_counter = state_reg.dphase & ~state_reg.dwrite &
                 (state_reg.daddr == OFS_COUNTER);
    rd_flags   = state_reg.dphase & ~state_reg.dwrite &
                 (state_reg.daddr == OFS_FLAGS);
    rd_status  = state_reg.dphase & ~state_reg.dwrite &
                 (state_reg.daddr == OFS_STATUS);
    wr_config  = state_reg.dphase & state_reg.dwrite &
                 (state_reg.daddr == OFS_CONFIG);
    irq_set    = 3'h0;

    // Strap capture once the synchroniser has filled; only stage two is read
    state_next.strap_s1 = {address_strap_high, address_strap_low};
    state_next.strap_s2 = state_reg.strap_s1;
    if (!state_reg.strap_done)
      state_next.strap_fill = state_reg.strap_fill + 2'h1;
    state_next.strap_done = state_reg.strap_done | state_reg.strap_fill[1];
    if (state_reg.strap_fill[1] && !state_reg.strap_done &&
        state_reg.strap_s2 == 2'b01)
      state_next.config_r[CFG_SYNC_ID] = 1'b1;

    // Recoding of upstream flags
    fresh.ap  = recode(rx.ap, field_in.ap_crc_err);
    fresh.ff  = recode(rx.ff, field_in.ff_crc_err &
                       ~state_reg.config_r[CFG_FLAG_MASK]);
    fresh.anc = recode(rx.anc, field_in.anc_err);
    if (!field_in.packet_seen)
    begin
      fresh.ap.ues  = 1'b1;
      fresh.ff.ues  = 1'b1;
      fresh.anc.ues = 1'b1;
    end

    // Field error against sensitivity
    field_err = sensed(fresh.anc, state_reg.sense[4:0]) |
                sensed(fresh.ap, state_reg.sense[9:5]) |
                sensed(fresh.ff, state_reg.sense[14:10]);

    if (field_in.field_end)
    begin
      state_next.out_flags = fresh;
      state_next.generated = ~field_in.packet_seen;
      if (field_err)
        irq_set[IRQ_ERR_FIELD] = 1'b1;
      if (!field_in.packet_seen)
        irq_set[IRQ_NO_PACKET] = 1'b1;
    end

    // Sticky flag holding
    if (rd_flags)
      state_next.held = '0;
    if (field_in.field_end)
      state_next.held = (state_reg.config_r[CFG_STICKY] && !rd_flags)
                      ? (state_reg.held | fresh) : fresh;

    // Errored field counter
    if (field_in.field_end && field_err)
    begin
      state_next.count = state_reg.count + 1'b1;
      if (&state_reg.count)
        irq_set[IRQ_CNT_WRAP] = 1'b1;
    end
    if (rd_counter && state_reg.config_r[CFG_CLR_READ])
      state_next.count = '0;
    if (state_reg.config_r[CFG_CLEAR])
      state_next.count = '0;

    // Standard selection
    if (state_reg.config_r[CFG_OVERRIDE])
      state_next.std = {state_reg.config_r[CFG_COMPOSITE],
                        state_reg.config_r[CFG_FIELD_RATE]};
    else
      state_next.std = {field_in.auto_composite, field_in.auto_625};

    // Ancillary indication output
    state_next.anc_ind = anc_present |
      (state_reg.config_r[CFG_SYNC_ID] & sync_id_present);

    // Bus data phase
    state_next.dphase = ahb_go;
    if (ahb_go)
    begin
      state_next.dwrite = ahb_req.hwrite;
      state_next.daddr  = ahb_req.haddr[7:0];
    end
    state_next.rdata = 32'h0000_0000;
    if (ahb_go && !ahb_req.hwrite)
    begin
      case (ahb_req.haddr[7:0])
        OFS_CONFIG:   state_next.rdata = {23'h0, state_reg.config_r};
        OFS_SENSE:    state_next.rdata = {17'h0, state_reg.sense};
        OFS_STATUS:   state_next.rdata = {29'h0, state_reg.irq_stat};
        OFS_MASK:     state_next.rdata = {29'h0, state_reg.irq_mask};
        OFS_COUNTER:  state_next.rdata = {11'h0, state_reg.count};
        OFS_FLAGS:    state_next.rdata = {17'h0, state_reg.held};
        OFS_STANDARD: state_next.rdata = {29'h0,
                        state_reg.config_r[CFG_COMPONENT], state_reg.std};
        default:      state_next.rdata = 32'h0000_0000;
      endcase
    end
    // Status read clears; new events win over the clear
    if (rd_status)
      state_next.irq_stat = irq_set;
    else
      state_next.irq_stat = state_reg.irq_stat | irq_set;
    if (state_reg.dphase && state_reg.dwrite)
    begin
      case (state_reg.daddr)
        OFS_CONFIG: state_next.config_r = hwdata[8:0];
        OFS_SENSE:  state_next.sense    = hwdata[14:0];
        OFS_MASK:   state_next.irq_mask = hwdata[2:0];
        default:    state_next.sense    = state_next.sense;
      endcase
    end
    state_next.irq_o = |(state_next.irq_stat & state_next.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= STATE_RST;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hrdata           = state_reg.rdata;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign anc_indication   = state_reg.anc_ind;
  assign flags_out        = state_reg.out_flags;
  assign packet_generated = state_reg.generated;
  assign video_standard   = state_reg.std;
  assign irq              = state_reg.irq_o;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_clear_holds_zero: assert property (
    state_reg.config_r[CFG_CLEAR] |=> state_reg.count == '0)
    else $error("counter not held at zero");
  a_count_step: assert property (
    field_in.field_end && field_err && !state_reg.config_r[CFG_CLEAR] &&
    !rd_counter |=> state_reg.count == $past(state_reg.count) + 1'b1)
    else $error("counter did not step");
  a_read_clear: assert property (
    rd_counter && state_reg.config_r[CFG_CLR_READ] && !field_in.field_end
    |=> state_reg.count == '0)
    else $error("counter not cleared on read");
  a_override_std: assert property (
    state_reg.config_r[CFG_OVERRIDE] |=> video_standard ==
    {$past(state_reg.config_r[CFG_COMPOSITE]),
     $past(state_reg.config_r[CFG_FIELD_RATE])})
    else $error("override standard ignored");
  a_sync_id_ind: assert property (
    !anc_present && sync_id_present |=>
    anc_indication == $past(state_reg.config_r[CFG_SYNC_ID]))
    else $error("indication select wrong");
  a_idh_recoded: assert property (
    field_in.field_end && field_in.packet_seen && field_in.in_flags.ap.idh
    |=> flags_out.ap.ida && !flags_out.ap.idh)
    else $error("internal flag not recoded");
  a_edh_recoded: assert property (
    field_in.field_end && field_in.packet_seen && field_in.in_flags.ff.edh
    |=> flags_out.ff.eda)
    else $error("error flag not recoded");
  a_no_packet_ues: assert property (
    field_in.field_end && !field_in.packet_seen
    |=> packet_generated && flags_out.ap.ues && flags_out.ff.ues)
    else $error("unknown status not set");
  a_irq_drop: assert property (
    state_reg.dphase && !state_reg.dwrite && state_reg.daddr == OFS_STATUS
    && !field_in.field_end |=> !irq)
    else $error("interrupt not released on read");
  a_irq_level: assert property (
    irq == |(state_reg.irq_stat & state_reg.irq_mask))
    else $error("interrupt level wrong");

  // Standard selection checks
  a_auto_std: assert property (
    !state_reg.config_r[CFG_OVERRIDE] |=> video_standard ==
    {$past(field_in.auto_composite), $past(field_in.auto_625)})
    else $error("auto standard not followed");
  a_field_rate: assert property (
    state_reg.config_r[CFG_OVERRIDE] |=>
    video_standard[0] == $past(state_reg.config_r[CFG_FIELD_RATE]))
    else $error("field rate select ignored");
  a_composite: assert property (
    state_reg.config_r[CFG_OVERRIDE] |=>
    video_standard[1] == $past(state_reg.config_r[CFG_COMPOSITE]))
    else $error("composite select ignored");
  a_std_readback: assert property (
    ahb_go && !ahb_req.hwrite && ahb_req.haddr[7:0] == OFS_STANDARD
    |=> hrdata[2] == $past(state_reg.config_r[CFG_COMPONENT]))
    else $error("component rate not reported");

  // Indication and strap checks
  a_anc_only: assert property (
    anc_present |=> anc_indication)
    else $error("ancillary data not indicated");
  a_strap_set: assert property (
    state_reg.strap_fill[1] && !state_reg.strap_done &&
    state_reg.strap_s2 == 2'b01 && !wr_config
    |=> state_reg.config_r[CFG_SYNC_ID])
    else $error("strap did not select sync identifiers");

  // Counter checks
  a_clear_on_write: assert property (
    wr_config && hwdata[CFG_CLEAR] |=> ##1 state_reg.count == '0)
    else $error("counter clear write ignored");
  a_count_stable: assert property (
    !(field_in.field_end && field_err) && !rd_counter &&
    !state_reg.config_r[CFG_CLEAR] |=> $stable(state_reg.count))
    else $error("counter moved without an errored field");

  // Flag recoding checks
  a_ap_local: assert property (
    field_in.field_end && field_in.ap_crc_err |=> flags_out.ap.edh)
    else $error("picture error not flagged");
  a_ff_local: assert property (
    field_in.field_end && field_in.ff_crc_err &&
    !state_reg.config_r[CFG_FLAG_MASK] |=> flags_out.ff.edh)
    else $error("field error not flagged");
  a_ff_masked: assert property (
    field_in.field_end && state_reg.config_r[CFG_FLAG_MASK]
    |=> !flags_out.ff.edh)
    else $error("masked field error flagged");
  a_ida_passed: assert property (
    field_in.field_end && field_in.packet_seen && field_in.in_flags.ff.ida
    |=> flags_out.ff.ida && !flags_out.ff.idh)
    else $error("internal flag not passed");
  a_eda_recoded: assert property (
    field_in.field_end && field_in.packet_seen && field_in.in_flags.ap.edh
    |=> flags_out.ap.eda)
    else $error("picture flag not recoded");

  // Sticky flag checks
  a_sticky_hold: assert property (
    state_reg.config_r[CFG_STICKY] && !rd_flags |=>
    (state_reg.held & $past(state_reg.held)) == $past(state_reg.held))
    else $error("sticky flag lost before read");
  a_flags_read_clr: assert property (
    rd_flags && !field_in.field_end |=> state_reg.held == '0)
    else $error("flags not cleared by read");

  c_error_field: cover property (field_in.field_end && field_err);
  c_no_packet: cover property (field_in.field_end && !field_in.packet_seen);
  c_irq_then_read: cover property (irq ##[1:20] !irq);
  c_sticky_read: cover property (rd_flags && state_reg.config_r[CFG_STICKY]);
  c_strap_set: cover property (state_reg.strap_fill[1] && !state_reg.strap_done);
endmodule : edh_recode

//--- edh_stream_model.sv
// Stream side model: per-field reports and ancillary markers
`timescale 1ns/1ps
module edh_stream_model
  import edh_pkg::*;
(
  input  wire logic              hclk,
  output edh_pkg::edh_field_type field_in,
  output logic                   anc_present,
  output logic                   sync_id_present
);

  // Quiet start, no field in flight
  initial
  begin
    field_in = '0;
    anc_present = 1'b0;
    sync_id_present = 1'b0;
  end

  // One field report; the end pulse stands for a single edge
  task automatic send_field(input logic p, input logic a, input logic f,
                            input edh_flags_type x, input logic s);
    @(posedge hclk);
    field_in <= '{1'b1, p, a, f, 1'b0, x, s, 1'b0};
    @(posedge hclk);
    field_in.field_end <= 1'b0;
    field_in.in_flags <= ~x; // Stale flags scrambled
    repeat (2) @(posedge hclk);
  endtask : send_field

  // Marker levels for the ancillary indication
  task automatic set_marks(input logic a, input logic s);
    @(posedge hclk);
    anc_present <= a;
    sync_id_present <= s;
  endtask : set_marks

endmodule : edh_stream_model

//--- edh_config_and_flag_recoding_test.sv
// Self-checking bench for the config and flag recoding block
`timescale 1ns/1ps
module edh_config_and_flag_recoding_test;
  import edh_pkg::*;
  logic            hclk = 1'b0;
  logic            hresetn = 1'b0;
  logic            hsel = 1'b0;
  logic            hwrite = 1'b0;
  logic [1:0]      htrans = 2'b00;
  logic [2:0]      hsize = 3'b010;
  logic [31:0]     haddr = 32'h0;
  logic [31:0]     hwdata = 32'h0;
  logic [31:0]     hrdata, rd;
  logic [1:0]      video_standard;
  logic            hreadyout, hresp, irq, anc_indication, packet_generated;
  logic            anc_present, sync_id_present;
  logic            strap_high = 1'b0;
  logic            strap_low = 1'b1;
  int              err_count = 0;
  int              checks = 0;
  edh_flags_type   flags_out, fl;
  edh_field_type   field_in;
  edh_ahb_req_type ahb_req;

  // One slave, so its ready is the bus ready
  assign ahb_req = {hsel, htrans, hwrite, hsize, haddr, hreadyout};

  // Free running clock
  always #50 hclk = ~hclk;

  edh_recode edh_recode_inst (
    .hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .address_strap_high(strap_high), .address_strap_low(strap_low),
    .field_in(field_in), .anc_present(anc_present),
    .sync_id_present(sync_id_present), .anc_indication(anc_indication),
    .flags_out(flags_out), .packet_generated(packet_generated),
    .video_standard(video_standard), .irq(irq));

  edh_stream_model edh_stream_model_inst (
    .hclk(hclk), .field_in(field_in), .anc_present(anc_present),
    .sync_id_present(sync_id_present));

  ////////////////////////////////////////
  task automatic check_val(input string n, input logic [31:0] e,
                           input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : check_val

  // Single word transfer: address phase, then data phase
  task automatic ahb_xfer(input logic w, input logic [7:0] a,
                          input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb_xfer(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
    ahb_xfer(1'b0, a, 32'h0);
    check_val(n, e, rd);
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : wait_cyc

  task automatic fld(input logic p, input logic a, input logic f,
                     input edh_flags_type x, input logic s);
    edh_stream_model_inst.send_field(p, a, f, x, s);
  endtask : fld

  task automatic mark_chk(input logic a, input logic s, input logic e);
    edh_stream_model_inst.set_marks(a, s);
    wait_cyc(2);
    check_val("anc_ind", {31'h0, e}, {31'h0, anc_indication});
  endtask : mark_chk

  ////////////////////////////////////////
  task automatic test_reset();
    rd_chk("config", OFS_CONFIG, 32'h10);
    rd_chk("sense", OFS_SENSE, 32'h7fff);
    rd_chk("mask", OFS_MASK, 32'h0);
    rd_chk("unmapped", 8'h1c, 32'h0);
    mark_chk(1'b0, 1'b1, 1'b1);
    wr(OFS_CONFIG, 32'h0);
    mark_chk(1'b0, 1'b1, 1'b0);
    mark_chk(1'b1, 1'b0, 1'b1);
  endtask : test_reset

  task automatic test_standard();
    logic [31:0] c;
    logic [31:0] s;
    for (int i = 0; i < 4; i++)
    begin
      c = 32'h0a | {29'h0, i[0], 1'b0, i[1]};
      s = {30'h0, i[1:0]};
      wr(OFS_CONFIG, c);
      wait_cyc(2);
      check_val("std", s, {30'h0, video_standard});
      rd_chk("cfg", OFS_CONFIG, c);
      rd_chk("std_reg", OFS_STANDARD, s | 32'h4);
    end
    wr(OFS_CONFIG, 32'h0);
    fld(1'b1, 1'b0, 1'b0, '0, 1'b1);
    check_val("auto", 32'h1, {30'h0, video_standard});
    rd_chk("std_auto", OFS_STANDARD, 32'h1);
  endtask : test_standard

  task automatic test_counter();
    repeat (3) fld(1'b1, 1'b1, 1'b0, '0, 1'b0);
    rd_chk("count", OFS_COUNTER, 32'h3);
    wr(OFS_CONFIG, 32'h20);
    fld(1'b1, 1'b1, 1'b0, '0, 1'b0);
    rd_chk("held", OFS_COUNTER, 32'h0);
    wr(OFS_CONFIG, 32'h40);
    repeat (2) fld(1'b1, 1'b1, 1'b0, '0, 1'b0);
    rd_chk("resume", OFS_COUNTER, 32'h2);
    rd_chk("clear_on_read", OFS_COUNTER, 32'h0);
    wr(OFS_CONFIG, 32'h0);
  endtask : test_counter

  task automatic test_recode();
    edh_flags_type e;
    fl = '0;
    fl.ap.idh = 1'b1;
    fl.ap.edh = 1'b1;
    fl.ff.ida = 1'b1;
    fl.anc.ues = 1'b1;
    e = fl;
    e.ap.idh = 1'b0;
    e.ap.ida = 1'b1;
    e.ap.eda = 1'b1;
    fld(1'b1, 1'b1, 1'b0, fl, 1'b0);
    check_val("flags", {17'h0, e}, {17'h0, flags_out});
    wr(OFS_CONFIG, 32'h100);
    fld(1'b1, 1'b0, 1'b1, '0, 1'b0);
    check_val("ff_mask", 32'h0, {31'h0, flags_out.ff.edh});
    wr(OFS_CONFIG, 32'h0);
    fld(1'b1, 1'b0, 1'b1, '0, 1'b0);
    check_val("ff_edh", 32'h1, {31'h0, flags_out.ff.edh});
    fld(1'b0, 1'b0, 1'b0, '0, 1'b0);
    check_val("gen", 32'h1, {31'h0, packet_generated});
    check_val("ues", 32'h1, {31'h0, flags_out.ap.ues});
  endtask : test_recode

  task automatic test_irq();
    ahb_xfer(1'b0, OFS_STATUS, 32'h0);
    wr(OFS_MASK, 32'h1);
    fld(1'b1, 1'b1, 1'b0, '0, 1'b0);
    check_val("irq_set", 32'h1, {31'h0, irq});
    rd_chk("status", OFS_STATUS, 32'h1);
    wait_cyc(2);
    check_val("irq_clr", 32'h0, {31'h0, irq});
    wr(OFS_MASK, 32'h0);
    fld(1'b1, 1'b1, 1'b0, '0, 1'b0);
    check_val("irq_mask", 32'h0, {31'h0, irq});
    rd_chk("status2", OFS_STATUS, 32'h1);
  endtask : test_irq

  task automatic test_sticky();
    wr(OFS_CONFIG, 32'h80);
    fld(1'b1, 1'b1, 1'b0, '0, 1'b0);
    fld(1'b1, 1'b0, 1'b0, '0, 1'b0);
    ahb_xfer(1'b0, OFS_FLAGS, 32'h0);
    check_val("sticky", 32'h1, {31'h0, rd[0]});
    ahb_xfer(1'b0, OFS_FLAGS, 32'h0);
    check_val("read_clr", 32'h0, {31'h0, rd[0]});
  endtask : test_sticky

  // Mid-run reset with straps that must not select sync identifiers
  task automatic test_strap();
    @(posedge hclk);
    hresetn    <= 1'b0;
    strap_high <= 1'b1;
    strap_low  <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    wait_cyc(4);
    rd_chk("strap_10", OFS_CONFIG, 32'h0);
    rd_chk("sense_rst", OFS_SENSE, 32'h7fff);
    rd_chk("count_rst", OFS_COUNTER, 32'h0);
  endtask : test_strap

  task automatic print_verdict();
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Main sequence after reset
  initial
  begin
    fl = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    wait_cyc(4);
    test_reset();
    test_standard();
    test_counter();
    test_recode();
    test_irq();
    test_sticky();
    test_strap();
    print_verdict();
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge hclk);
    err_count++;
    print_verdict();
  end

endmodule : edh_config_and_flag_recoding_test
